// [design/power_mode_regs.svh]
// constants for the power mode start-up sequencer
`ifndef POWER_MODE_REGS_SVH
`define POWER_MODE_REGS_SVH
`define SETTLE_TIME_NS 1000
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + 7) / 8)
`define RESET_VECTOR_ADDR 32'h0000_0000
`define SEG_LIMIT_B 6'h18
`define SEG_LIMIT_C 6'h20
`define SEG_LIMIT_MAX 6'h28
`define CLK_DIV_NONE 3'h0
`define PSAVE_SLEEP_MAX 2'h3
`endif

// [design/power_mode_pkg.sv]
// types for the power mode start-up sequencer
`default_nettype none
package power_mode_pkg;
  typedef enum logic [5:0] {
    ST_SETTLE = 6'h01,
    ST_RUN = 6'h02,
    ST_SLEEP = 6'h04,
    ST_WAIT = 6'h08,
    ST_RETAIN = 6'h10,
    ST_BACKUP = 6'h20
  } pm_state_t;
  typedef logic [1:0] run_mode_t;
endpackage : power_mode_pkg
`default_nettype wire

// [design/power_mode_startup_sequencer.sv]
// power mode and start-up sequencer with display pad cluster assignment
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_regs.svh"

module power_mode_startup_sequencer
  import power_mode_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // supply monitors and reset sources
  input wire logic analog_supply_low,
  input wire logic reset_request,
  // processor requests
  input wire logic wait_for_interrupt_instruction,
  input wire logic deep_sleep_select,
  input wire logic backup_mode_select,
  input wire logic retention_select,
  input wire logic [1:0] sleep_depth,
  input wire logic [1:0] run_mode_select,
  input wire logic wake_event,
  input wire logic osc_32k_enable,
  // segment display
  input wire logic segment_display_controller_enable,
  input wire logic [5:0] segment_count,
  // i/o configuration
  input wire logic io_config_write,
  input wire logic [7:0] io_config_in,
  // reset and clock control
  output logic core_reset_n,
  output logic cpu_run,
  output logic system_rc_oscillator_select,
  output logic frequency_locked_loop_enable,
  output logic pll_enable,
  output logic [2:0] clock_divider,
  output logic [31:0] reset_vector,
  output logic ahb_clock_run,
  output logic apb_clock_run,
  output logic clock_sources_run,
  output logic osc_32k_run,
  output logic core_domain_power,
  output logic backup_domain_power,
  // mode report
  output logic [1:0] run_mode,
  output logic initial_run_mode,
  output logic [7:0] io_config,
  // display clusters, high means display mode
  output logic display_pad_cluster_a,
  output logic display_pad_cluster_b,
  output logic display_pad_cluster_c
);

  // ******************************
  // state and decode
  // ******************************
  pm_state_t state;
  pm_state_t next_state;
  logic [7:0] settle_count;
  run_mode_t saved_run_mode;
  logic [1:0] sleep_cfg;
  wire chip_reset = analog_supply_low | reset_request;
  wire settle_done = (settle_count == 8'(`SETTLE_CYCLES - 1));
  wire in_run = (state == ST_RUN);
  wire want_backup = deep_sleep_select & backup_mode_select;
  wire want_retain = deep_sleep_select & ~backup_mode_select & retention_select;
  wire want_wait = deep_sleep_select & ~backup_mode_select & ~retention_select;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_SETTLE: if (settle_done) next_state = ST_RUN;
      ST_RUN: begin
        if (wait_for_interrupt_instruction) begin
          if (want_backup) next_state = ST_BACKUP;
          else if (want_retain) next_state = ST_RETAIN;
          else if (want_wait) next_state = ST_WAIT;
          else next_state = ST_SLEEP;
        end
      end
      // requests are ignored here; only wake or a chip reset leaves
      ST_SLEEP, ST_WAIT, ST_RETAIN, ST_BACKUP: if (wake_event) next_state = ST_RUN;
      default: next_state = ST_SETTLE;
    endcase
  end

  // ******************************
  // sequencer registers
  // ******************************
  // reset always wins, so a monitor trip forces the settle sequence again
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SETTLE;
      settle_count <= 8'h00;
    end else if (chip_reset) begin
      state <= ST_SETTLE;
      settle_count <= 8'h00;
    end else begin
      state <= next_state;
      settle_count <= (state == ST_SETTLE && !settle_done) ? settle_count + 8'h01 : 8'h00;
    end
  end

  // run mode is captured at entry and kept while saving power
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      saved_run_mode <= 2'h0;
      sleep_cfg <= 2'h0;
    end else if (chip_reset || state == ST_SETTLE) begin
      saved_run_mode <= 2'h0;
      sleep_cfg <= 2'h0;
    end else if (in_run) begin
      saved_run_mode <= run_mode_select;
      if (wait_for_interrupt_instruction) sleep_cfg <= sleep_depth;
    end
  end

  // io configuration lives in the backup domain, untouched by mode changes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) io_config <= 8'h00;
    else if (io_config_write && in_run) io_config <= io_config_in;
  end

  // ******************************
  // outputs
  // ******************************
  assign core_reset_n = (state != ST_SETTLE) & (state != ST_BACKUP);
  assign cpu_run = in_run;
  assign system_rc_oscillator_select = 1'b1;
  assign frequency_locked_loop_enable = 1'b0;
  assign pll_enable = 1'b0;
  assign clock_divider = `CLK_DIV_NONE;
  assign reset_vector = `RESET_VECTOR_ADDR;
  wire sleeping = (state == ST_SLEEP);
  wire deep = (state == ST_WAIT) | (state == ST_RETAIN) | (state == ST_BACKUP);
  assign ahb_clock_run = in_run | (sleeping & (sleep_cfg == 2'h0));
  assign apb_clock_run = in_run | (sleeping & (sleep_cfg < 2'h2));
  assign clock_sources_run = ~deep & ~(sleeping & (sleep_cfg == `PSAVE_SLEEP_MAX));
  assign osc_32k_run = osc_32k_enable;
  assign core_domain_power = (state != ST_BACKUP);
  assign backup_domain_power = 1'b1;
  assign run_mode = saved_run_mode;
  assign initial_run_mode = (saved_run_mode == 2'h0);

  // ******************************
  // display pad clusters
  // ******************************
  wire seg_on = segment_display_controller_enable & (segment_count != 6'h00);
  assign display_pad_cluster_a = seg_on;
  assign display_pad_cluster_b = seg_on & (segment_count > `SEG_LIMIT_B);
  assign display_pad_cluster_c = seg_on & (segment_count > `SEG_LIMIT_C);

  // ******************************
  // assertions
  // ******************************
  sequence s_wfi_in_run;
    in_run && wait_for_interrupt_instruction && !chip_reset;
  endsequence

  property p_settle;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(core_reset_n) |-> $past(settle_done) || $past(state) == ST_BACKUP;
  endproperty
  a_settle: assert property (p_settle) else $error("reset released early");

  property p_monitor_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      analog_supply_low |=> state == ST_SETTLE && !core_reset_n;
  endproperty
  a_monitor_reset: assert property (p_monitor_reset) else $error("monitor reset missed");

  property p_backup_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      s_wfi_in_run and (deep_sleep_select && backup_mode_select) |=> !core_domain_power;
  endproperty
  a_backup_entry: assert property (p_backup_entry) else $error("backup not entered");

  property p_halt;
    @(posedge clk_sys) disable iff (!rst_n)
      s_wfi_in_run |=> !cpu_run;
  endproperty
  a_halt: assert property (p_halt) else $error("cpu kept running");

  property p_wake_return;
    @(posedge clk_sys) disable iff (!rst_n)
      (!in_run && state != ST_SETTLE && wake_event && !chip_reset) |=>
        in_run && run_mode == $past(run_mode);
  endproperty
  a_wake_return: assert property (p_wake_return) else $error("wrong run mode on wake");

  property p_reset_initial;
    @(posedge clk_sys) disable iff (!rst_n)
      reset_request |=> initial_run_mode && state == ST_SETTLE;
  endproperty
  a_reset_initial: assert property (p_reset_initial) else $error("reset not to initial");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (deep && !wake_event && !chip_reset) |=> $stable(state);
  endproperty
  a_hold: assert property (p_hold) else $error("left save mode without wake");

  property p_io_kept;
    @(posedge clk_sys) disable iff (!rst_n)
      !in_run |=> $stable(io_config);
  endproperty
  a_io_kept: assert property (p_io_kept) else $error("io changed in save mode");

  property p_clusters;
    @(posedge clk_sys) disable iff (!rst_n)
      seg_on && segment_count <= 6'h18 |-> !display_pad_cluster_b && !display_pad_cluster_c;
  endproperty
  a_clusters: assert property (p_clusters) else $error("cluster taken below 25");

  property p_deep_clocks;
    @(posedge clk_sys) disable iff (!rst_n)
      deep |-> !clock_sources_run && !ahb_clock_run && !apb_clock_run;
  endproperty
  a_deep_clocks: assert property (p_deep_clocks) else $error("clocks running deep");

  sequence s_sleep_req;
    s_wfi_in_run ##0 !deep_sleep_select;
  endsequence

  sequence s_deep_req;
    s_wfi_in_run ##0 deep_sleep_select && !backup_mode_select;
  endsequence

  property p_settle_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      state == ST_SETTLE && !settle_done && !chip_reset |=> state == ST_SETTLE && !core_reset_n;
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("settle ended early");

  property p_settle_exit;
    @(posedge clk_sys) disable iff (!rst_n)
      state == ST_SETTLE && settle_done && !chip_reset |=> in_run && core_reset_n;
  endproperty
  a_settle_exit: assert property (p_settle_exit) else $error("settle did not end");

  property p_initial_mode;
    @(posedge clk_sys) disable iff (!rst_n)
      state == ST_SETTLE |-> initial_run_mode && !cpu_run;
  endproperty
  a_initial_mode: assert property (p_initial_mode) else $error("not in initial run mode");

  property p_sleep_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      s_sleep_req |=> sleeping && sleep_cfg == $past(sleep_depth);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_sleep_ahb;
    @(posedge clk_sys) disable iff (!rst_n)
      sleeping && sleep_cfg != 2'h0 |-> !ahb_clock_run && !cpu_run;
  endproperty
  a_sleep_ahb: assert property (p_sleep_ahb) else $error("bus clock kept in sleep");

  property p_sleep_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      sleeping && !wake_event && !chip_reset |=> sleeping;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep without wake");

  property p_wait_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      s_deep_req ##0 !retention_select |=> state == ST_WAIT && !clock_sources_run;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait not entered");

  property p_retain_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      s_deep_req ##0 retention_select |=> state == ST_RETAIN && core_domain_power;
  endproperty
  a_retain_entry: assert property (p_retain_entry) else $error("retention not entered");

  property p_backup_domain;
    @(posedge clk_sys) disable iff (!rst_n)
      !core_domain_power |-> backup_domain_power && !core_reset_n && !cpu_run;
  endproperty
  a_backup_domain: assert property (p_backup_domain) else $error("backup domain wrong");

  property p_io_write;
    @(posedge clk_sys) disable iff (!rst_n)
      io_config_write && in_run |=> io_config == $past(io_config_in);
  endproperty
  a_io_write: assert property (p_io_write) else $error("io write lost in run");

  property p_cluster_off;
    @(posedge clk_sys) disable iff (!rst_n)
      !seg_on |-> !display_pad_cluster_a && !display_pad_cluster_b && !display_pad_cluster_c;
  endproperty
  a_cluster_off: assert property (p_cluster_off) else $error("cluster taken while off");

  property p_cluster_full;
    @(posedge clk_sys) disable iff (!rst_n)
      seg_on && segment_count > `SEG_LIMIT_C |-> display_pad_cluster_b && display_pad_cluster_c;
  endproperty
  a_cluster_full: assert property (p_cluster_full) else $error("cluster free above 32");

endmodule : power_mode_startup_sequencer
`default_nettype wire

// [bench/cpu_supply_model.sv]
// processor core and supply monitor model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module cpu_supply_model (
  // clock
  input wire logic clk_sys,
  // mode requests
  output logic wait_for_interrupt_instruction,
  output logic deep_sleep_select,
  output logic backup_mode_select,
  output logic retention_select,
  output logic [1:0] sleep_depth,
  output logic [1:0] run_mode_select,
  output logic wake_event,
  // reset sources
  output logic reset_request,
  output logic analog_supply_low
);
  initial begin
    {wait_for_interrupt_instruction, deep_sleep_select, backup_mode_select} = 3'h0;
    {retention_select, wake_event, reset_request, analog_supply_low} = 4'h0;
    sleep_depth = 2'h0;
    run_mode_select = 2'h2;
  end
  // selects settle one edge before the request is raised
  task automatic enter(input logic d, input logic b, input logic r, input logic [1:0] s);
    @(posedge clk_sys);
    deep_sleep_select <= d;
    backup_mode_select <= b;
    retention_select <= r;
    sleep_depth <= s;
    @(posedge clk_sys);
    wait_for_interrupt_instruction <= 1'h1;
    @(posedge clk_sys);
    wait_for_interrupt_instruction <= 1'h0;
  endtask : enter
  // a select moved while saving must not leak into the restored mode
  task automatic wake();
    @(posedge clk_sys);
    wake_event <= 1'h1;
    run_mode_select <= 2'h1;
    @(posedge clk_sys);
    wake_event <= 1'h0;
    run_mode_select <= 2'h2;
  endtask : wake
  task automatic pulse_reset(input logic supply);
    @(posedge clk_sys);
    analog_supply_low <= supply;
    reset_request <= ~supply;
    @(posedge clk_sys);
    {analog_supply_low, reset_request} <= 2'h0;
  endtask : pulse_reset
endmodule : cpu_supply_model
`default_nettype wire

// [bench/power_mode_startup_sequencer_tb_top.sv]
// self-checking bench for the power mode start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module power_mode_startup_sequencer_tb_top;
  import power_mode_pkg::*;
  // ********
  // signals
  // ********
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic wait_for_interrupt_instruction, deep_sleep_select, backup_mode_select, retention_select;
  logic wake_event, reset_request, analog_supply_low, osc_32k_enable, io_config_write;
  logic segment_display_controller_enable, core_reset_n, cpu_run, system_rc_oscillator_select;
  logic frequency_locked_loop_enable, pll_enable, ahb_clock_run, apb_clock_run;
  logic clock_sources_run, osc_32k_run, core_domain_power, backup_domain_power;
  logic initial_run_mode, display_pad_cluster_a, display_pad_cluster_b, display_pad_cluster_c;
  logic [1:0] sleep_depth, run_mode_select, run_mode;
  logic [2:0] clock_divider;
  logic [5:0] segment_count;
  logic [7:0] io_config_in, io_config;
  logic [31:0] reset_vector;
  wire [3:0] clocks_now = {cpu_run, ahb_clock_run, apb_clock_run, clock_sources_run};
  wire [2:0] pads_now = {display_pad_cluster_a, display_pad_cluster_b, display_pad_cluster_c};
  logic [5:0] cnt [7] = '{6'h0, 6'h1, 6'h18, 6'h19, 6'h20, 6'h21, 6'h28};
  logic [2:0] pads [7] = '{3'h0, 3'h4, 3'h4, 3'h6, 3'h6, 3'h7, 3'h7};
  int fail_count = 0;
  int tests_run = 0;
  always #4 clk_sys = ~clk_sys;
  power_mode_startup_sequencer power_mode_startup_sequencer_i (.clk_sys, .rst_n,
    .analog_supply_low, .reset_request, .wait_for_interrupt_instruction, .deep_sleep_select,
    .backup_mode_select, .retention_select, .sleep_depth, .run_mode_select, .wake_event,
    .osc_32k_enable, .segment_display_controller_enable, .segment_count, .io_config_write,
    .io_config_in, .core_reset_n, .cpu_run, .system_rc_oscillator_select,
    .frequency_locked_loop_enable, .pll_enable, .clock_divider, .reset_vector, .ahb_clock_run,
    .apb_clock_run, .clock_sources_run, .osc_32k_run, .core_domain_power,
    .backup_domain_power, .run_mode, .initial_run_mode, .io_config, .display_pad_cluster_a,
    .display_pad_cluster_b, .display_pad_cluster_c);
  cpu_supply_model cpu_supply_model_i (.clk_sys, .wait_for_interrupt_instruction,
    .deep_sleep_select, .backup_mode_select, .retention_select, .sleep_depth,
    .run_mode_select, .wake_event, .reset_request, .analog_supply_low);
  // ********
  // helpers
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wait_release();
    for (int i = 0; i < 200 && core_reset_n !== 1'h1; i++) tick(1);
    `CHK("rel initial_run_mode", 3'h7, {core_reset_n, initial_run_mode, run_mode == 2'h0})
  endtask : wait_release
  task automatic wake_check();
    cpu_supply_model_i.wake();
    #1;
    `CHK("wake", 3'h6, {cpu_run, run_mode})
  endtask : wake_check
  task automatic io_write(input logic [7:0] v);
    @(posedge clk_sys);
    io_config_write <= 1'h1;
    io_config_in <= v;
    @(posedge clk_sys);
    io_config_write <= 1'h0;
  endtask : io_write
  // ********
  // scenarios
  // ********
  task automatic t_startup();
    tick(124);
    `CHK("settle", 1'h0, core_reset_n)
    tick(1);
    `CHK("release", 3'h7, {core_reset_n, cpu_run, initial_run_mode})
    `CHK("rc", 1'h1, system_rc_oscillator_select)
    `CHK("fll pll", 2'h0, {frequency_locked_loop_enable, pll_enable})
    `CHK("div", 3'h0, clock_divider)
    `CHK("vector", 32'h0, reset_vector)
  endtask : t_startup
  task automatic t_sleep();
    for (int d = 0; d < 4; d++) begin
      cpu_supply_model_i.enter(1'h0, 1'h0, 1'h0, d[1:0]);
      #1;
      `CHK("sleep", {1'h0, d == 0, d < 2, d < 3}, clocks_now)
      cpu_supply_model_i.enter(1'h1, 1'h1, 1'h0, 2'h0);
      #1;
      `CHK("no reentry", 2'h1, {cpu_run, core_domain_power})
      wake_check();
    end
  endtask : t_sleep
  task automatic t_deep();
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_sys);
      osc_32k_enable <= ~r[0];
      cpu_supply_model_i.enter(1'h1, 1'h0, r[0], 2'h3);
      #1;
      `CHK("deep", {4'h0, ~r[0], 1'h1}, {clocks_now, osc_32k_run, core_domain_power})
      wake_check();
    end
  endtask : t_deep
  task automatic t_backup();
    io_write(8'h5a);
    cpu_supply_model_i.enter(1'h1, 1'h1, 1'h0, 2'h0);
    #1;
    `CHK("backup", 4'h4, {core_domain_power, backup_domain_power, core_reset_n, cpu_run})
    io_write(8'h33);
    wake_check();
    `CHK("io kept", 9'h15a, {core_reset_n, io_config})
  endtask : t_backup
  task automatic t_reset();
    cpu_supply_model_i.pulse_reset(1'h1);
    #1;
    `CHK("supply reset", 1'h0, core_reset_n)
    wait_release();
    cpu_supply_model_i.enter(1'h1, 1'h0, 1'h1, 2'h0);
    cpu_supply_model_i.pulse_reset(1'h0);
    tick(1);
    wait_release();
  endtask : t_reset
  task automatic t_display();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      segment_display_controller_enable <= (i < 7);
      segment_count <= (i < 7) ? cnt[i] : 6'h28;
      tick(1);
      `CHK("clusters", (i < 7) ? pads[i] : 3'h0, pads_now)
    end
  endtask : t_display
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    {io_config_write, io_config_in, osc_32k_enable} = 10'h1;
    {segment_display_controller_enable, segment_count} = 7'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_startup();
    t_sleep();
    t_deep();
    t_backup();
    t_reset();
    t_display();
    end_sim();
  end
  // a hang shows as a missing release or wake
  initial begin
    #80000;
    fail_count++;
    end_sim();
  end
endmodule : power_mode_startup_sequencer_tb_top
`default_nettype wire
